// File: hw/usf_pkg.sv
// Shared constants and carrier types for the serial flag and data port
package usf_pkg;

  // Register byte offsets
  localparam logic [7:0] USF_OFS_CTRL_SECOND = 8'h14;
  localparam logic [7:0] USF_OFS_CTRL_THIRD  = 8'h10;
  localparam logic [7:0] USF_OFS_FLAGS_PRI   = 8'h08;
  localparam logic [7:0] USF_OFS_FLAGS_SEC   = 8'h0c;
  localparam logic [7:0] USF_OFS_DATA_BUF    = 8'h18;

  // Primary flag positions
  localparam int USF_B_TX_EMPTY = 7;
  localparam int USF_B_TX_DONE  = 6;
  localparam int USF_B_RX_FULL  = 5;
  localparam int USF_B_IDLE     = 4;
  localparam int USF_B_OVERRUN  = 3;
  localparam int USF_B_NOISE    = 2;
  localparam int USF_B_FRAME    = 1;
  localparam int USF_B_PARITY   = 0;

  // Secondary flag positions
  localparam int USF_B_BREAK    = 1;
  localparam int USF_B_RX_PROG  = 0;

  // Second control register positions
  localparam int USF_B_TXE_EN   = 7;
  localparam int USF_B_TC_EN    = 6;
  localparam int USF_B_RXF_EN   = 5;
  localparam int USF_B_IDLE_EN  = 4;
  localparam int USF_B_RX_ON    = 2;

  // Third control register positions
  localparam int USF_B_NINTH    = 7;
  localparam int USF_B_OR_EN    = 3;
  localparam int USF_B_NE_EN    = 2;
  localparam int USF_B_FE_EN    = 1;
  localparam int USF_B_PE_EN    = 0;

  // Reset values
  localparam logic [7:0] USF_RST_FLAGS_PRI = 8'hc0;
  localparam logic [7:0] USF_RST_CTRL      = 8'h00;
  localparam logic [2:0] USF_RST_SEC       = 3'h1;

  // Events from the receive shift engine, one-cycle pulses except ones_seen
  typedef struct packed {
    logic       char_done;
    logic [8:0] char_data;
    logic       noise;
    logic       stop_zero;
    logic       parity_bad;
    logic       brk;
    logic       ones_seen;
    logic       idle_char;
    logic       start_zero;
    logic       false_start;
  } usf_rx_evt_t;

  // Transmit engine status
  typedef struct packed {
    logic load;
    logic busy;
    logic queue;
  } usf_tx_evt_t;

  // Bus access phases
  typedef enum logic [2:0] {
    USF_BUS_IDLE   = 3'b001,
    USF_BUS_SETUP  = 3'b010,
    USF_BUS_ACCESS = 3'b100
  } usf_bus_t;

endpackage

// File: hw/usf_port.sv
// Serial status flags, error flags, interrupt requests and data buffer behind APB
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Framing error flag requests the error interrupt only while its enable is set.
// - Parity error flag requests interrupt while enabled; reset clears both enables.
// - Buffer handoff to shifter sets transmit-empty; requests interrupt when enabled.
// - Transmit-empty clears by status read while set, then buffer write; reset sets.
// - Complete flag sets when transmit-empty and nothing shifting; interrupts when enabled.
// - Complete flag clears once data, preamble or break queued; reset sets it.
// - Receive-full sets on shifter transfer, interrupts when enabled, clears status-then-data read.
// - Idle flag sets on idle line, interrupts if enabled, clears status-then-data read.
// - Idle flag waits for a receive-full after enabling receiver or clearing idle.
// - Character completing while buffer full sets overrun, is discarded, buffer kept.
// - Data read clears overrun only if overrun was set at the status read.
// - Noise sets noise flag, interrupts if enabled, clears status-then-data read.
// - Zero stop bit sets framing error; clears status-then-data read; reset clears.
// - Parity mismatch sets parity flag, interrupts if enabled, clears status-then-data read.
// - Break sets break, framing and full flags, clears ninth bit in nine-bit mode; break flag has no interrupt.
// - Break clears by second status read then data read; rearms after ones.
// - Zero in first sample slot sets in-progress indicator, which never interrupts.
// - False start or idle character clears the in-progress indicator.
// - Data reads give last received byte, writes load transmit byte, reset keeps.
// - Disabling the receiver stops reception; receiver flags then change only by status-then-data read.
module usf_port
  import usf_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire usf_rx_evt_t RX_EVT,
  input  wire usf_tx_evt_t TX_EVT,
  input  wire logic        NINE_BIT_MODE,
  output logic      [7:0]  TX_DATA,
  output logic             TX_DATA_VALID,
  output logic             RECEIVER_ON,
  output logic             IRQ_TX,
  output logic             IRQ_RX,
  output logic             IRQ_ERR
);

  usf_bus_t   bus_state;
  logic [7:0] flags_pri;
  logic [7:0] arm_pri;
  logic [7:0] ctrl_second;
  logic [7:0] ctrl_third;
  logic       break_seen_flag;
  logic       break_arm;
  logic       break_rearmed;
  logic       rx_in_progress_flag;
  logic       idle_allowed;
  logic [7:0] rx_buf;
  logic       rx_ninth_bit;
  logic [7:0] next_flags_pri;
  logic       acc_done;
  logic       wr_done;
  logic       rd_done;
  logic       rx_go;
  logic       rx_load;
  logic       data_rd;
  logic       data_wr;
  logic [7:0] set_pri;
  logic [7:0] clr_pri;

  // Register offset match
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // Known register offsets
  function automatic logic mapped(input logic [7:0] addr);
    return hit(addr, USF_OFS_CTRL_SECOND) | hit(addr, USF_OFS_CTRL_THIRD) |
           hit(addr, USF_OFS_FLAGS_PRI) | hit(addr, USF_OFS_FLAGS_SEC) |
           hit(addr, USF_OFS_DATA_BUF);
  endfunction

  // Completing access and its side-effect strobes
  assign acc_done = PSEL & PENABLE & PREADY;
  assign wr_done  = acc_done & PWRITE;
  assign rd_done  = acc_done & ~PWRITE;
  assign data_rd  = rd_done & hit(PADDR, USF_OFS_DATA_BUF);
  assign data_wr  = wr_done & hit(PADDR, USF_OFS_DATA_BUF);

  // Receiver events other than ones_seen only count while the receiver is on
  assign rx_go   = RECEIVER_ON;
  assign rx_load = rx_go & (RX_EVT.char_done | RX_EVT.brk) & ~flags_pri[USF_B_RX_FULL];

  // APB phase tracking, ready one cycle after setup
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bus_state <= USF_BUS_IDLE;
      PREADY    <= 1'b0;
    end else begin
      unique case (bus_state)
        USF_BUS_IDLE: begin
          bus_state <= (PSEL & ~PENABLE) ? USF_BUS_SETUP : USF_BUS_IDLE;
          PREADY    <= PSEL & ~PENABLE;
        end
        USF_BUS_SETUP: begin
          bus_state <= USF_BUS_ACCESS;
          PREADY    <= 1'b0;
        end
        USF_BUS_ACCESS: begin
          bus_state <= USF_BUS_IDLE;
          PREADY    <= 1'b0;
        end
        default: begin
          bus_state <= USF_BUS_IDLE;
          PREADY    <= 1'b0;
        end
      endcase
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (PSEL & ~PENABLE) begin
      PSLVERR <= ~mapped(PADDR);
      PRDATA  <= 32'h0;
      if (~PWRITE) begin
        if (hit(PADDR, USF_OFS_CTRL_SECOND))
          PRDATA <= {24'h0, ctrl_second};
        else if (hit(PADDR, USF_OFS_CTRL_THIRD))
          PRDATA <= {24'h0, rx_ninth_bit, ctrl_third[6:0]};
        else if (hit(PADDR, USF_OFS_FLAGS_PRI))
          PRDATA <= {24'h0, flags_pri};
        else if (hit(PADDR, USF_OFS_FLAGS_SEC))
          PRDATA <= {30'h0, break_seen_flag, rx_in_progress_flag};
        else if (hit(PADDR, USF_OFS_DATA_BUF))
          PRDATA <= {24'h0, rx_buf};
      end
    end
  end

  // Control registers and receiver enable
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_second <= USF_RST_CTRL;
      ctrl_third  <= USF_RST_CTRL;
    end else if (wr_done) begin
      if (hit(PADDR, USF_OFS_CTRL_SECOND))
        ctrl_second <= PWDATA[7:0] & 8'hf4;
      if (hit(PADDR, USF_OFS_CTRL_THIRD))
        ctrl_third <= PWDATA[7:0] & 8'h0f;
    end
  end

  // Transmit buffer, left untouched by reset
  always_ff @(posedge CORE_CLK) begin
    if (data_wr)
      TX_DATA <= PWDATA[7:0];
  end

  // Receive buffer and ninth bit, left untouched by reset
  always_ff @(posedge CORE_CLK) begin
    if (rx_load) begin
      rx_buf       <= RX_EVT.brk ? 8'h00 : RX_EVT.char_data[7:0];
      rx_ninth_bit <= RX_EVT.brk ? (NINE_BIT_MODE ? 1'b0 : rx_ninth_bit) :
                      (NINE_BIT_MODE ? RX_EVT.char_data[8] : RX_EVT.char_data[7]);
    end
  end

  // Hardware set terms for the primary flags
  always_comb begin
    set_pri = 8'h00;
    set_pri[USF_B_TX_EMPTY] = TX_EVT.load;
    set_pri[USF_B_RX_FULL]  = rx_load;
    set_pri[USF_B_IDLE]     = rx_go & RX_EVT.idle_char & idle_allowed;
    set_pri[USF_B_OVERRUN]  = rx_go & (RX_EVT.char_done | RX_EVT.brk) & flags_pri[USF_B_RX_FULL];
    set_pri[USF_B_NOISE]    = rx_go & RX_EVT.noise;
    set_pri[USF_B_FRAME]    = rx_go & (RX_EVT.stop_zero | (RX_EVT.brk & break_rearmed));
    set_pri[USF_B_PARITY]   = rx_go & RX_EVT.parity_bad;
  end

  // Software clear terms, each needing an armed status read
  always_comb begin
    clr_pri = 8'h00;
    clr_pri[USF_B_TX_EMPTY] = data_wr & arm_pri[USF_B_TX_EMPTY];
    clr_pri[USF_B_RX_FULL]  = data_rd & arm_pri[USF_B_RX_FULL];
    clr_pri[USF_B_IDLE]     = data_rd & arm_pri[USF_B_IDLE];
    clr_pri[USF_B_OVERRUN]  = data_rd & arm_pri[USF_B_OVERRUN];
    clr_pri[USF_B_NOISE]    = data_rd & arm_pri[USF_B_NOISE];
    clr_pri[USF_B_FRAME]    = data_rd & arm_pri[USF_B_FRAME];
    clr_pri[USF_B_PARITY]   = data_rd & arm_pri[USF_B_PARITY];
  end

  // Next primary flags, set beats clear except on the complete flag
  always_comb begin
    next_flags_pri = (flags_pri & ~clr_pri) | set_pri;
    // Queued work clears completion; an idle shifter with empty buffer sets it
    if (data_wr | TX_EVT.queue)
      next_flags_pri[USF_B_TX_DONE] = 1'b0;
    else if (flags_pri[USF_B_TX_EMPTY] & ~TX_EVT.busy)
      next_flags_pri[USF_B_TX_DONE] = 1'b1;
    else
      next_flags_pri[USF_B_TX_DONE] = flags_pri[USF_B_TX_DONE];
  end

  // Primary flag storage
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      flags_pri <= USF_RST_FLAGS_PRI;
    else
      flags_pri <= next_flags_pri;
  end

  // Arming by primary status read, spent by the data access
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      arm_pri <= 8'h00;
    else if (rd_done & hit(PADDR, USF_OFS_FLAGS_PRI))
      arm_pri <= flags_pri;
    else if (data_rd | data_wr)
      arm_pri <= 8'h00;
  end

  // Idle flag permission after a received character or break
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      idle_allowed <= 1'b0;
    else if (rx_load)
      idle_allowed <= 1'b1;
    else if (clr_pri[USF_B_IDLE] | (wr_done & hit(PADDR, USF_OFS_CTRL_SECOND) &
             PWDATA[USF_B_RX_ON] & ~RECEIVER_ON))
      idle_allowed <= 1'b0;
  end

  // Break flag with its arming and rearm by ones on the line
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      break_seen_flag <= 1'b0;
      break_arm       <= 1'b0;
      break_rearmed   <= USF_RST_SEC[0];
    end else begin
      if (rx_go & RX_EVT.brk & break_rearmed)
        break_seen_flag <= 1'b1;
      else if (data_rd & break_arm)
        break_seen_flag <= 1'b0;
      if (rd_done & hit(PADDR, USF_OFS_FLAGS_SEC))
        break_arm <= break_seen_flag;
      else if (data_rd)
        break_arm <= 1'b0;
      if (rx_go & RX_EVT.brk)
        break_rearmed <= 1'b0;
      else if (RX_EVT.ones_seen)
        break_rearmed <= 1'b1;
    end
  end

  // Reception in progress indicator
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      rx_in_progress_flag <= 1'b0;
    else if (rx_go & RX_EVT.start_zero)
      rx_in_progress_flag <= 1'b1;
    else if (rx_go & (RX_EVT.false_start | RX_EVT.idle_char))
      rx_in_progress_flag <= 1'b0;
  end

  // Registered interrupt requests and status outputs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      IRQ_TX        <= 1'b0;
      IRQ_RX        <= 1'b0;
      IRQ_ERR       <= 1'b0;
      TX_DATA_VALID <= 1'b0;
      RECEIVER_ON   <= 1'b0;
    end else begin
      IRQ_TX  <= (next_flags_pri[USF_B_TX_EMPTY] & ctrl_second[USF_B_TXE_EN]) |
                 (next_flags_pri[USF_B_TX_DONE] & ctrl_second[USF_B_TC_EN]);
      IRQ_RX  <= (next_flags_pri[USF_B_RX_FULL] & ctrl_second[USF_B_RXF_EN]) |
                 (next_flags_pri[USF_B_IDLE] & ctrl_second[USF_B_IDLE_EN]);
      IRQ_ERR <= (next_flags_pri[USF_B_OVERRUN] & ctrl_third[USF_B_OR_EN]) |
                 (next_flags_pri[USF_B_NOISE] & ctrl_third[USF_B_NE_EN]) |
                 (next_flags_pri[USF_B_FRAME] & ctrl_third[USF_B_FE_EN]) |
                 (next_flags_pri[USF_B_PARITY] & ctrl_third[USF_B_PE_EN]);
      TX_DATA_VALID <= ~next_flags_pri[USF_B_TX_EMPTY];
      RECEIVER_ON   <= (wr_done & hit(PADDR, USF_OFS_CTRL_SECOND)) ? PWDATA[USF_B_RX_ON] :
                       RECEIVER_ON;
    end
  end

  // Sequence of a completed primary status read
  sequence s_pri_read;
    rd_done && hit(PADDR, USF_OFS_FLAGS_PRI);
  endsequence

  a_frame_irq_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
    (flags_pri[USF_B_FRAME] && ctrl_third[USF_B_FE_EN]) |-> IRQ_ERR)
    else $error("framing error did not raise error request");

  a_enable_reset: assert property (@(posedge CORE_CLK)
    RST |=> (ctrl_third[USF_B_FE_EN] == 1'b0 && ctrl_third[USF_B_PE_EN] == 1'b0))
    else $error("error enables not cleared by reset");

  a_txe_set_load: assert property (@(posedge CORE_CLK) disable iff (RST)
    TX_EVT.load |=> flags_pri[USF_B_TX_EMPTY])
    else $error("transmit empty not set on load");

  a_txe_clear_seq: assert property (@(posedge CORE_CLK) disable iff (RST)
    ($fell(flags_pri[USF_B_TX_EMPTY])) |-> $past(data_wr && arm_pri[USF_B_TX_EMPTY]))
    else $error("transmit empty cleared without status read and write");

  a_tc_queue_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    (TX_EVT.queue || data_wr) |=> !flags_pri[USF_B_TX_DONE])
    else $error("complete flag not cleared on queue");

  a_overrun_keep: assert property (@(posedge CORE_CLK) disable iff (RST)
    (rx_go && RX_EVT.char_done && flags_pri[USF_B_RX_FULL]) |=>
      (flags_pri[USF_B_OVERRUN] && $stable(rx_buf)))
    else $error("overrun not flagged or buffer changed");

  a_overrun_late: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s_pri_read ##0 !flags_pri[USF_B_OVERRUN]) ##1
      (!data_rd && !(rd_done && hit(PADDR, USF_OFS_FLAGS_PRI)))[*6] ##1
      (data_rd && flags_pri[USF_B_OVERRUN]) |=> flags_pri[USF_B_OVERRUN])
    else $error("overrun cleared by unarmed data read");

  a_rx_full_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    (data_rd && arm_pri[USF_B_RX_FULL] && !rx_load) |=> !flags_pri[USF_B_RX_FULL])
    else $error("receive full not cleared by armed data read");

  a_idle_wait: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(flags_pri[USF_B_IDLE]) |-> $past(idle_allowed))
    else $error("idle set before a valid character");

  a_break_flags: assert property (@(posedge CORE_CLK) disable iff (RST)
    (rx_go && RX_EVT.brk && break_rearmed) |=> (break_seen_flag && flags_pri[USF_B_FRAME]))
    else $error("break did not set break and framing flags");

  a_prog_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    (rx_go && RX_EVT.false_start && !RX_EVT.start_zero) |=> !rx_in_progress_flag)
    else $error("in-progress not cleared on false start");

  a_rx_off_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!RECEIVER_ON && !data_rd) |=> $stable(flags_pri[5:0]))
    else $error("receiver flags changed while receiver off");

endmodule

`default_nettype wire

// File: dv/usf_engine_model.sv
// Far-side engine model: transmit shifter timing and receive line events
`timescale 1ns/1ps
`default_nettype none
module usf_engine_model
  import usf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tx_valid,
  input  wire logic [1:0] tx_slack,
  input  wire logic       rx_go,
  input  wire logic [3:0] rx_kind,
  input  wire logic [8:0] rx_byte,
  output usf_rx_evt_t     rx_evt,
  output usf_tx_evt_t     tx_evt
);
  logic [3:0] wait_cnt;
  logic [2:0] busy_cnt;
  logic [8:0] last_byte;
  logic       ones;
  logic [8:0] pick;

  // One-hot event select from the bench request
  assign pick = rx_go ? (9'h001 << rx_kind) : 9'h000;

  // Shifter takes the buffer after a slack, then shifts for seven cycles
  always_ff @(posedge clk) begin
    tx_evt.load <= 1'b0;
    tx_evt.queue <= 1'b0;
    if (rst) begin
      wait_cnt <= 4'h0;
      busy_cnt <= 3'h0;
      tx_evt.busy <= 1'b0;
    end else if (busy_cnt != 3'h0) begin
      busy_cnt <= busy_cnt - 3'h1;
      tx_evt.busy <= (busy_cnt != 3'h1);
    end else if (tx_valid && wait_cnt == {2'b10, tx_slack}) begin
      tx_evt.load <= 1'b1;
      tx_evt.busy <= 1'b1;
      busy_cnt <= 3'h7;
      wait_cnt <= 4'h0;
    end else if (tx_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // Receive events as single-cycle pulses, ones_seen held as a level; data lines scramble when idle
  always_ff @(posedge clk) begin
    rx_evt.char_done <= pick[0];
    rx_evt.char_data <= pick[0] ? rx_byte : ~last_byte;
    rx_evt.noise <= pick[1];
    rx_evt.stop_zero <= pick[2];
    rx_evt.parity_bad <= pick[3];
    rx_evt.brk <= pick[4];
    rx_evt.idle_char <= pick[5];
    rx_evt.start_zero <= pick[6];
    rx_evt.false_start <= pick[7];
    rx_evt.ones_seen <= ones;
    if (pick[0]) begin
      last_byte <= rx_byte;
    end
    if (rst) begin
      ones <= 1'b1;
    end else if (pick[4]) begin
      ones <= 1'b0;
    end else if (pick[8]) begin
      ones <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: dv/usf_port_tb.sv
// Self-checking bench for the serial flag and data port
`timescale 1ns/1ps
`default_nettype none
module usf_port_tb
  import usf_pkg::*;
;
  localparam logic [7:0] PRI = USF_OFS_FLAGS_PRI;
  localparam logic [7:0] SEC = USF_OFS_FLAGS_SEC;
  localparam logic [7:0] C2  = USF_OFS_CTRL_SECOND;
  localparam logic [7:0] C3  = USF_OFS_CTRL_THIRD;
  localparam logic [7:0] DAT = USF_OFS_DATA_BUF;
  localparam logic [7:0] BAD = 8'h04;
  localparam logic [3:0] K_CHAR = 4'h0, K_NOISE = 4'h1, K_STOP = 4'h2, K_BRK = 4'h4;
  localparam logic [3:0] K_IDLE = 4'h5, K_START = 4'h6, K_FALSE = 4'h7, K_ONES = 4'h8;

  logic        CORE_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic        NINE_BIT_MODE = 1'b1, RX_GO = 1'b0;
  logic [7:0]  PADDR = 8'h00, TX_DATA, held, b;
  logic [31:0] PWDATA = 32'h0, PRDATA, seed = 32'he7af2fc9;
  logic [3:0]  RX_KIND = 4'h0;
  logic [8:0]  RX_BYTE = 9'h000;
  logic        PREADY, PSLVERR, TX_DATA_VALID, RECEIVER_ON, IRQ_TX, IRQ_RX, IRQ_ERR;
  usf_rx_evt_t rxe;
  usf_tx_evt_t txe;
  logic [35:0] rdq[$];
  logic [8:0]  txq[$];
  int          error_cnt = 0, comparisons = 0;

  // Bus clock
  always #50 CORE_CLK = ~CORE_CLK;

  usf_port usf_port_i (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_EVT(rxe),
    .TX_EVT(txe), .NINE_BIT_MODE(NINE_BIT_MODE), .TX_DATA(TX_DATA), .TX_DATA_VALID(TX_DATA_VALID),
    .RECEIVER_ON(RECEIVER_ON), .IRQ_TX(IRQ_TX), .IRQ_RX(IRQ_RX), .IRQ_ERR(IRQ_ERR));

  usf_engine_model usf_engine_model_i (.clk(CORE_CLK), .rst(RST), .tx_valid(TX_DATA_VALID),
    .tx_slack(seed[1:0]), .rx_go(RX_GO), .rx_kind(RX_KIND), .rx_byte(RX_BYTE), .rx_evt(rxe), .tx_evt(txe));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic complete_run();
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
    if (n >= 20) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  // Read noting expected irq lines, error and data
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [2:0] irq);
    rdq.push_back({irq, a === BAD, 24'h0, d});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic send(input logic [3:0] k);
    seed = lfsr(seed);
    b = seed[7:0];
    RX_KIND <= k;
    RX_BYTE <= {1'b1, b};
    RX_GO <= 1'b1;
    @(posedge CORE_CLK);
    RX_GO <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
  endtask

  task automatic tx_byte();
    seed = lfsr(seed);
    txq.push_back({1'b1, seed[7:0]});
    wr(DAT, seed[7:0]);
  endtask

  task automatic wait_tx(input logic idle);
    int n;
    n = 0;
    while ((TX_DATA_VALID !== 1'b0 || (idle && txe.busy !== 1'b0)) && n < 200) begin
      @(posedge CORE_CLK);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      complete_run();
    end
  endtask

  // Completed reads and shifter handoffs against the oldest note
  always @(posedge CORE_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && rdq.size() > 0)
      chk("read", rdq.pop_front(), {IRQ_TX, IRQ_RX, IRQ_ERR, PSLVERR, PRDATA});
    if (txe.load === 1'b1 && txq.size() > 0)
      chk("tx_data", {27'h0, txq.pop_front()}, {27'h0, TX_DATA_VALID, TX_DATA});
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    rd(PRI, 8'hc0, 3'b000);
    rd(SEC, 8'h00, 3'b000);
    rd(BAD, 8'h00, 3'b000);
    wr(BAD, 8'hff);
    wr(C2, 8'h34);
    chk("receiver_on", 36'h1, {35'h0, RECEIVER_ON});
    wr(C3, 8'h0f);
    send(K_CHAR);
    held = b;
    send(K_CHAR);
    rd(PRI, 8'he8, 3'b011);
    rd(DAT, held, 3'b011);
    rd(PRI, 8'hc0, 3'b000);
    send(K_CHAR);
    held = b;
    rd(PRI, 8'he0, 3'b010);
    send(K_CHAR);
    rd(DAT, held, 3'b011);
    rd(PRI, 8'hc8, 3'b001);
    rd(DAT, held, 3'b001);
    rd(PRI, 8'hc0, 3'b000);
    send(K_IDLE);
    rd(PRI, 8'hd0, 3'b010);
    rd(DAT, held, 3'b010);
    send(K_IDLE);
    rd(PRI, 8'hc0, 3'b000);
    send(K_START);
    rd(SEC, 8'h01, 3'b000);
    send(K_FALSE);
    rd(SEC, 8'h00, 3'b000);
    send(K_START);
    send(K_IDLE);
    rd(SEC, 8'h00, 3'b000);
    for (int i = 0; i < 3; i++) begin
      send(K_NOISE + 4'(i));
      rd(PRI, 8'hc0 | (8'h04 >> i), 3'b001);
      rd(DAT, held, 3'b001);
      rd(PRI, 8'hc0, 3'b000);
    end
    wr(C3, 8'h00);
    send(K_STOP);
    rd(PRI, 8'hc2, 3'b000);
    rd(DAT, held, 3'b000);
    NINE_BIT_MODE <= 1'b0;
    send(K_CHAR);
    held = b;
    rd(C3, {b[7], 7'h00}, 3'b010);
    NINE_BIT_MODE <= 1'b1;
    rd(PRI, 8'he0, 3'b010);
    rd(DAT, held, 3'b010);
    send(K_BRK);
    rd(SEC, 8'h02, 3'b010);
    rd(PRI, 8'he2, 3'b010);
    rd(C3, 8'h00, 3'b010);
    rd(DAT, 8'h00, 3'b010);
    rd(SEC, 8'h00, 3'b000);
    rd(PRI, 8'hc0, 3'b000);
    send(K_BRK);
    rd(SEC, 8'h00, 3'b010);
    send(K_ONES);
    send(K_BRK);
    rd(SEC, 8'h02, 3'b010);
    rd(PRI, 8'hea, 3'b010);
    rd(DAT, 8'h00, 3'b010);
    rd(PRI, 8'hc0, 3'b000);
    send(K_CHAR);
    held = b;
    wr(C2, 8'h30);
    chk("receiver_on", 36'h0, {35'h0, RECEIVER_ON});
    send(K_CHAR);
    rd(PRI, 8'he0, 3'b010);
    rd(DAT, held, 3'b010);
    wr(C2, 8'hc0);
    wr(DAT, 8'h5a);
    rd(PRI, 8'hc0, 3'b100);
    tx_byte();
    rd(PRI, 8'h00, 3'b000);
    wait_tx(1'b0);
    rd(PRI, 8'h80, 3'b100);
    tx_byte();
    wait_tx(1'b1);
    rd(PRI, 8'hc0, 3'b100);
    RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    rd(DAT, held, 3'b000);
    rd(C2, 8'h00, 3'b000);
    rd(C3, 8'h80, 3'b000);
    rd(PRI, 8'hc0, 3'b000);
    chk("pending", 36'h0, {32'h0, 4'(rdq.size() + txq.size())});
    complete_run();
  end
endmodule
`default_nettype wire
